// [design/cod_core.sv]
// Core instruction decode, operand addressing and sequencing
`timescale 1ns/1ps
module cod_core
  import cod_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  output logic [11:0]      PROG_ADDR,
  input  wire logic [7:0]  PROG_RDATA,
  output logic [7:0]       DATA_ADDR,
  output logic             DATA_RD,
  output logic             DATA_WE,
  output logic [7:0]       DATA_WDATA,
  input  wire logic [7:0]  DATA_RDATA,
  input  wire logic        INT_REQ,
  input  wire logic [11:0] INT_VEC,
  output logic [7:0]       ACC,
  output logic             ZERO_FLAG,
  output logic             CARRY_FLAG,
  output logic [3:0]       ADDR_MODE,
  output logic [1:0]       INSTR_LEN,
  output logic             INSTR_DONE,
  output logic             ILLEGAL,
  output logic             HALTED
);

  cod_ph_t     ph_r, ph_nxt;
  logic [2:0]  last;
  logic [3:0]  mode, alu;
  logic [1:0]  dst;
  logic [7:0]  op_r, op, b1_r, b2_r, b2, dv_r, dv, dv_now, ea, opnd;
  logic [7:0]  p1_r, p2_r, r3_r, r4_r, acc_r, int_rd, res;
  logic [11:0] pc_r, pcn, ext_tgt, pc_inc, span, stk_top;
  logic [11:0] stk [STK_N];
  logic [2:0]  sp_r;
  logic [1:0]  len;
  logic        z_r, c_r, zs_r, cs_r, in_int_r, halt_r, cres;
  logic        zupd, cupd, ill, rd, call, pop_d, hlt, reti;
  logic        ret, irq_tk, tbit, rel_tk;

  function automatic logic int_hit(input logic [7:0] a);
    return (a[7:2] == ADR_P1[7:2]) || (a == ADR_ACC);
  endfunction

  function automatic logic [8:0] alu_f(input cod_alu_t k,
    input logic [7:0] a, input logic [7:0] b, input logic c,
    input logic [2:0] bn);
    unique case (k)
      K_PASS:  return {c, b};
      K_STA:   return {c, a};
      K_ADD:   return {1'b0, a} + {1'b0, b};
      K_AND:   return {1'b0, a & b};
      K_SUB,
      K_CP:    return {1'b0, a} - {1'b0, b};
      K_INC:   return {c, b + 8'h01};
      K_DEC:   return {c, b - 8'h01};
      K_COM:   return {a[7], ~a};
      K_RLC:   return {a, c};
      K_SLA:   return {a, 1'b0};
      K_SETB:  return {c, b | (8'h01 << bn)};
      K_CLRB:  return {c, b & ~(8'h01 << bn)};
      default: return {c, a};
    endcase
  endfunction

  // ********************************************************
  // Decode
  // ********************************************************
  assign op = (ph_r == PH1) ? PROG_RDATA : op_r;

  always_comb begin
    mode = AM_INH;
    len = LEN1;
    last = PH1;
    alu = K_NONE;
    dst = D_NONE;
    {zupd, cupd, ill, rd, call, pop_d, hlt, reti} = 8'h00;
    if (!op[7]) begin
      mode = AM_REL;
    end else begin
      unique case (op[7:4])
        HI_JP, HI_CALL: begin
          mode = AM_EXT;
          len = LEN2;
          last = PH3;
          call = (op[7:4] == HI_CALL);
        end
        HI_BTB: begin
          mode = AM_BTB;
          len = LEN3;
          last = PH4;
          rd = 1'b1;
          cupd = 1'b1;
        end
        HI_BIT: begin
          mode = AM_BITD;
          len = LEN2;
          last = PH3;
          rd = 1'b1;
          dst = D_MEM;
          alu = op[3] ? K_SETB : K_CLRB;
        end
        HI_SHA, HI_SHB: begin
          last = PH3;
          zupd = 1'b1;
          mode = AM_SHORT;
          unique case (op[3:2])
            SG_LDA: begin
              {alu, dst, rd, ill} = {K_PASS, D_ACC, 1'b1, op[4]};
            end
            SG_STA: begin
              {alu, dst, ill} = {K_STA, D_MEM, op[4]};
            end
            SG_IND: begin
              mode = AM_IND;
              rd = (op[1:0] != 2'h1);
              unique case (op[1:0])
                2'h0: {alu, dst} = {K_PASS, D_ACC};
                2'h1: {alu, dst} = {K_STA, D_MEM};
                2'h2: {alu, dst} = {K_INC, D_MEM};
                2'h3: {alu, dst} = {K_DEC, D_MEM};
              endcase
            end
            SG_INC: begin
              {alu, dst, rd} = {op[4] ? K_DEC : K_INC, D_MEM, 1'b1};
            end
          endcase
        end
        HI_DIR: begin
          {mode, len, last, rd, zupd} = {AM_DIR, LEN2, PH3, 2'h3};
          if (!op[0] && op[3:0] >= LO_ADD && op[3:0] <= LO_CP) begin
            cupd = 1'b1;
          end
          if ((op[0] || op[3:0] == LO_LDIA) && op[3:0] >= LO_LDIA &&
              op[3:0] <= LO_CPI) begin
            {mode, rd} = {AM_IMM, 1'b0};
            cupd = (op[3:0] > LO_LDIM);
          end
          unique case (op[3:0])
            LO_LDA, LO_LDIA: {alu, dst} = {K_PASS, D_ACC};
            LO_STA:  {alu, dst, rd} = {K_STA, D_MEM, 1'b0};
            LO_LDIM: begin
              {mode, len, alu, dst} = {AM_IMM, LEN3, K_PASS, D_MEM};
              {zupd, rd} = 2'h0;
            end
            LO_ADD, LO_ADDI: {alu, dst} = {K_ADD, D_ACC};
            LO_AND, LO_ANDI: {alu, dst} = {K_AND, D_ACC};
            LO_SUB, LO_SUBI: {alu, dst} = {K_SUB, D_ACC};
            LO_CP, LO_CPI:   alu = K_CP;
            LO_INC: {alu, dst} = {K_INC, D_MEM};
            LO_DEC: {alu, dst} = {K_DEC, D_MEM};
            default: ill = 1'b1;
          endcase
        end
        HI_INH: begin
          unique case (op[3:0])
            LO_NOP: ;
            LO_RET: pop_d = 1'b1;
            LO_RETI: {pop_d, reti} = 2'h3;
            LO_WAIT, LO_STOP: hlt = 1'b1;
            LO_COM, LO_RLC, LO_SLA: begin
              {last, dst, zupd, cupd} = {PH3, D_ACC, 2'h3};
              alu = (op[3:0] == LO_COM) ? K_COM :
                    (op[3:0] == LO_RLC) ? K_RLC : K_SLA;
            end
            default: ill = 1'b1;
          endcase
        end
      endcase
    end
    if (ill) begin
      {mode, len, last, alu, dst} = {AM_INH, LEN1, PH1, K_NONE, D_NONE};
      {zupd, cupd, rd} = 3'h0;
    end
  end

  // ********************************************************
  // Operands and execution
  // ********************************************************
  assign ret = (ph_r == last);
  assign irq_tk = (ph_r == PH0) && INT_REQ && !in_int_r;
  assign b2 = (ph_r == PH3) ? PROG_RDATA : b2_r;
  assign dv = (ph_r == PH3) ? dv_now : dv_r;
  assign dv_now = int_hit(DATA_ADDR) ? int_rd : DATA_RDATA;
  assign opnd = (mode != AM_IMM) ? dv : (len == LEN3) ? b2 : b1_r;
  assign {cres, res} = alu_f(cod_alu_t'(alu), acc_r, opnd, c_r, op[2:0]);
  assign tbit = dv[op[2:0]];
  assign ext_tgt = {op[3:0], b1_r};
  assign pc_inc = pc_r + 12'h001;
  assign span = {8'h00, op[3:0]};
  assign stk_top = stk[(sp_r == 3'h0) ? 3'h0 : sp_r - 3'h1];

  // Internal registers answer in data space instead of the bus
  always_comb begin
    unique case (DATA_ADDR)
      ADR_P1:  int_rd = p1_r;
      ADR_P2:  int_rd = p2_r;
      ADR_R3:  int_rd = r3_r;
      ADR_R4:  int_rd = r4_r;
      default: int_rd = acc_r;
    endcase
  end

  always_comb begin
    if (mode == AM_SHORT) begin
      ea = {ADR_P1[7:2], op[1:0]};
    end else if (mode == AM_IND) begin
      ea = op[4] ? p2_r : p1_r;
    end else begin
      ea = PROG_RDATA;
    end
  end

  always_comb begin
    unique case (cod_cnd_t'(op[6:5]))
      CND_NZ: rel_tk = !z_r;
      CND_Z:  rel_tk = z_r;
      CND_NC: rel_tk = !c_r;
      CND_C:  rel_tk = c_r;
    endcase
    pcn = pc_r + {10'h000, len};
    if (mode == AM_REL && rel_tk) begin
      pcn = op[4] ? pc_r - span : pc_inc + span;
    end else if (mode == AM_EXT) begin
      pcn = ext_tgt;
    end else if (mode == AM_BTB && tbit == op[3]) begin
      pcn = pc_inc + {{4{b2[7]}}, b2};
    end else if (pop_d) begin
      pcn = stk_top;
    end
  end

  always_comb begin
    unique case (ph_r)
      PH0: ph_nxt = (irq_tk || halt_r) ? PH0 : PH1;
      PH1: ph_nxt = (last == PH1) ? PH0 : PH2;
      PH2: ph_nxt = PH3;
      PH3: ph_nxt = (last == PH3) ? PH0 : PH4;
      PH4: ph_nxt = PH0;
      default: ph_nxt = PH0;
    endcase
  end

  // ********************************************************
  // State
  // ********************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ph_r <= PH0;
      {op_r, b1_r, b2_r, dv_r} <= 32'h0000_0000;
    end else begin
      ph_r <= ph_nxt;
      if (ph_r == PH1) op_r <= PROG_RDATA;
      if (ph_r == PH2) b1_r <= PROG_RDATA;
      if (ph_r == PH3) {b2_r, dv_r} <= {PROG_RDATA, dv_now};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {pc_r, halt_r, in_int_r} <= {RST_PC, 2'h0};
    end else if (irq_tk) begin
      {pc_r, halt_r, in_int_r} <= {INT_VEC, 2'h1};
    end else if (ph_r == PH0 && INT_REQ) begin
      halt_r <= 1'b0;
    end else if (ret) begin
      pc_r <= pcn;
      halt_r <= hlt;
      if (reti) in_int_r <= 1'b0;
    end
  end

  // Full stack overwrites its top entry; empty pop leaves depth 0
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sp_r <= 3'h0;
    end else if (irq_tk || (ret && call)) begin
      sp_r <= (sp_r == STK_N) ? STK_N : sp_r + 3'h1;
    end else if (ret && pop_d) begin
      sp_r <= (sp_r == 3'h0) ? 3'h0 : sp_r - 3'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (irq_tk || (ret && call)) begin
      stk[(sp_r == STK_N) ? STK_N - 3'h1 : sp_r] <=
        irq_tk ? pc_r : pc_r + 12'h002;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {acc_r, p1_r, p2_r, r3_r, r4_r} <= 40'h00_0000_0000;
    end else if (ret && dst == D_ACC) begin
      acc_r <= res;
    end else if (ret && dst == D_MEM) begin
      unique case (DATA_ADDR)
        ADR_P1:  p1_r <= res;
        ADR_P2:  p2_r <= res;
        ADR_R3:  r3_r <= res;
        ADR_R4:  r4_r <= res;
        ADR_ACC: acc_r <= res;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {z_r, c_r, zs_r, cs_r} <= 4'h0;
    end else if (irq_tk) begin
      {zs_r, cs_r} <= {z_r, c_r};
    end else if (ret && reti) begin
      {z_r, c_r} <= {zs_r, cs_r};
    end else if (ret) begin
      if (zupd) z_r <= (res == 8'h00);
      if (cupd) c_r <= (mode == AM_BTB) ? tbit : cres;
    end
  end

  // ********************************************************
  // Bus and status outputs
  // ********************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {PROG_ADDR, DATA_ADDR, DATA_RD, DATA_WE, DATA_WDATA} <= 30'h0;
    end else begin
      DATA_RD <= (ph_r == PH2) && rd && !int_hit(ea);
      DATA_WE <= ret && dst == D_MEM && !int_hit(DATA_ADDR);
      if (ph_r == PH2) DATA_ADDR <= ea;
      if (ret) DATA_WDATA <= res;
      if (irq_tk) PROG_ADDR <= INT_VEC;
      else if (ret) PROG_ADDR <= pcn;
      else if (ph_r == PH1) PROG_ADDR <= pc_inc;
      else if (ph_r == PH2) PROG_ADDR <= pc_r + 12'h002;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {ADDR_MODE, INSTR_LEN, INSTR_DONE, ILLEGAL} <= {AM_INH, 4'h0};
    end else begin
      INSTR_DONE <= ret;
      ILLEGAL <= ret && ill;
      if (ret) {ADDR_MODE, INSTR_LEN} <= {mode, len};
    end
  end

  assign ACC = acc_r;
  assign ZERO_FLAG = z_r;
  assign CARRY_FLAG = c_r;
  assign HALTED = halt_r;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  short_addr_a: assert property ((ph_r == PH2 && mode == AM_SHORT)
    |=> DATA_ADDR[7:2] == ADR_P1[7:2]) else $error("short address bad");
  ind_sel_a: assert property ((ph_r == PH2 && mode == AM_IND &&
    !op_r[4]) |=> DATA_ADDR == $past(p1_r)) else $error("pointer bad");
  ext_tgt_a: assert property ((ret && mode == AM_EXT)
    |=> PROG_ADDR == $past(ext_tgt)) else $error("jump target bad");
  ld_cyc_a: assert property ((ph_r == PH1 &&
    PROG_RDATA == {HI_DIR, LO_LDA}) |-> ##2 ret ##1 INSTR_DONE)
    else $error("load not four cycles");
  rel_span_a: assert property ((ret && mode == AM_REL && rel_tk)
    |=> (PROG_ADDR - $past(pc_r) + 12'h00F) <= 12'h01F)
    else $error("relative span out of range");
  rel_miss_a: assert property ((ret && mode == AM_REL && !rel_tk)
    |=> PROG_ADDR == $past(pc_inc)) else $error("no fall through");
  pc_adv_a: assert property ((ret && mode == AM_DIR)
    |=> PROG_ADDR - $past(pc_r) == 12'h002) else $error("pc step bad");
  stk_lim_a: assert property (sp_r <= STK_N)
    else $error("stack depth over six");
  zflag_a: assert property ((ret && zupd && !reti)
    |=> ZERO_FLAG == ($past(res) == 8'h00)) else $error("zero flag bad");
  ldim_z_a: assert property ((ret && mode == AM_IMM && len == LEN3)
    |=> $stable(ZERO_FLAG)) else $error("immediate store moved zero");
  btb_c_a: assert property ((ret && mode == AM_BTB)
    |=> CARRY_FLAG == $past(tbit)) else $error("tested bit not in carry");

endmodule // cod_core

// [design/cod_pkg.sv]
// Constants and types shared by the operand addressing decoder
package cod_pkg;

  localparam int         PC_W    = 12;
  localparam logic [11:0] RST_PC = 12'h000;

  // Data space map of internal registers
  localparam logic [7:0] ADR_P1  = 8'h80;
  localparam logic [7:0] ADR_P2  = 8'h81;
  localparam logic [7:0] ADR_R3  = 8'h82;
  localparam logic [7:0] ADR_R4  = 8'h83;
  localparam logic [7:0] ADR_ACC = 8'hFF;

  localparam logic [2:0] STK_N = 3'h6;

  // Opcode high nibbles; opcodes below 80h are relative branches
  localparam logic [3:0] HI_JP   = 4'h8;
  localparam logic [3:0] HI_CALL = 4'h9;
  localparam logic [3:0] HI_BTB  = 4'hA;
  localparam logic [3:0] HI_BIT  = 4'hB;
  localparam logic [3:0] HI_SHA  = 4'hC;
  localparam logic [3:0] HI_SHB  = 4'hD;
  localparam logic [3:0] HI_DIR  = 4'hE;
  localparam logic [3:0] HI_INH  = 4'hF;

  // Direct and immediate group, low nibble
  localparam logic [3:0] LO_LDA  = 4'h0;
  localparam logic [3:0] LO_STA  = 4'h1;
  localparam logic [3:0] LO_LDIA = 4'h2;
  localparam logic [3:0] LO_LDIM = 4'h3;
  localparam logic [3:0] LO_ADD  = 4'h4;
  localparam logic [3:0] LO_ADDI = 4'h5;
  localparam logic [3:0] LO_AND  = 4'h6;
  localparam logic [3:0] LO_ANDI = 4'h7;
  localparam logic [3:0] LO_SUB  = 4'h8;
  localparam logic [3:0] LO_SUBI = 4'h9;
  localparam logic [3:0] LO_CP   = 4'hA;
  localparam logic [3:0] LO_CPI  = 4'hB;
  localparam logic [3:0] LO_INC  = 4'hC;
  localparam logic [3:0] LO_DEC  = 4'hD;

  // Inherent group, low nibble
  localparam logic [3:0] LO_NOP  = 4'h0;
  localparam logic [3:0] LO_RET  = 4'h1;
  localparam logic [3:0] LO_RETI = 4'h2;
  localparam logic [3:0] LO_WAIT = 4'h3;
  localparam logic [3:0] LO_STOP = 4'h4;
  localparam logic [3:0] LO_COM  = 4'h5;
  localparam logic [3:0] LO_RLC  = 4'h6;
  localparam logic [3:0] LO_SLA  = 4'h7;

  // Short/indirect group, opcode bits 3:2
  localparam logic [1:0] SG_LDA = 2'h0;
  localparam logic [1:0] SG_STA = 2'h1;
  localparam logic [1:0] SG_IND = 2'h2;
  localparam logic [1:0] SG_INC = 2'h3;

  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  typedef enum logic [3:0] {
    AM_IMM, AM_DIR, AM_SHORT, AM_EXT, AM_REL,
    AM_BITD, AM_BTB, AM_IND, AM_INH
  } cod_mode_t;

  typedef enum logic [1:0] {
    CND_NZ = 2'h0, CND_Z = 2'h1, CND_NC = 2'h2, CND_C = 2'h3
  } cod_cnd_t;

  typedef enum logic [2:0] {
    PH0 = 3'b000, PH1 = 3'b001, PH2 = 3'b011, PH3 = 3'b010, PH4 = 3'b110
  } cod_ph_t;

  typedef enum logic [3:0] {
    K_NONE, K_PASS, K_STA, K_ADD, K_AND, K_SUB, K_CP,
    K_INC, K_DEC, K_COM, K_RLC, K_SLA, K_SETB, K_CLRB
  } cod_alu_t;

  typedef enum logic [1:0] {D_NONE, D_ACC, D_MEM} cod_dst_t;

endpackage

// [test/cod_core_bench.sv]
// Self-checking bench for the operand addressing decoder
`timescale 1ns/1ps
module cod_core_bench
  import cod_pkg::*;
;
  logic        MCLK       = 1'b0;
  logic        RST        = 1'b1;
  logic [7:0]  PROG_RDATA = 8'hF0;
  logic [7:0]  DATA_RDATA = 8'h00;
  logic        INT_REQ    = 1'b0;
  logic [11:0] INT_VEC    = 12'h7A0;
  logic [11:0] PROG_ADDR;
  logic [7:0]  DATA_ADDR;
  logic        DATA_RD;
  logic        DATA_WE;
  logic [7:0]  DATA_WDATA;
  logic [7:0]  ACC;
  logic        ZERO_FLAG;
  logic        CARRY_FLAG;
  logic [3:0]  ADDR_MODE;
  logic [1:0]  INSTR_LEN;
  logic        INSTR_DONE;
  logic        ILLEGAL;
  logic        HALTED;
  logic [7:0]  prog [0:4095];
  logic [7:0]  dmem [0:255];
  int          err_count  = 0;
  int          checks     = 0;
  int          cyc        = 0;

  // Flags f = {zero, carry, illegal, memory check}
  typedef struct {
    logic [23:0] op;
    logic [3:0]  md;
    logic [1:0]  ln;
    int          cy;
    logic [11:0] npc;
    logic [7:0]  acc;
    logic [3:0]  f;
    logic [15:0] m;
  } cod_row_t;

  // Each row runs at address 001h behind a NOP at 000h
  cod_row_t rows [38] = '{
    '{24'hE040F0, AM_DIR, LEN2, 4, 12'h003, 8'h00, 4'b1000, 16'h0},
    '{24'hE020F0, AM_DIR, LEN2, 4, 12'h003, 8'h21, 4'b0000, 16'h0},
    '{24'hE27EF0, AM_IMM, LEN2, 4, 12'h003, 8'h7E, 4'b0000, 16'h0},
    '{24'hE200F0, AM_IMM, LEN2, 4, 12'h003, 8'h00, 4'b1000, 16'h0},
    '{24'hE33000, AM_IMM, LEN3, 4, 12'h004, 8'h00, 4'b0001, 16'h3000},
    '{24'hE12CF0, AM_DIR, LEN2, 4, 12'h003, 8'h00, 4'b1001, 16'h2C00},
    '{24'hC3F0F0, AM_SHORT, LEN1, 4, 12'h002, 8'h00, 4'b1000, 16'h0},
    '{24'hC8F0F0, AM_IND, LEN1, 4, 12'h002, 8'h01, 4'b0000, 16'h0},
    '{24'hD8F0F0, AM_IND, LEN1, 4, 12'h002, 8'h01, 4'b0000, 16'h0},
    '{24'h8567F0, AM_EXT, LEN2, 4, 12'h567, 8'h00, 4'b0000, 16'h0},
    '{24'h9ABCF0, AM_EXT, LEN2, 4, 12'hABC, 8'h00, 4'b0000, 16'h0},
    '{24'h03F0F0, AM_REL, LEN1, 2, 12'h005, 8'h00, 4'b0000, 16'h0},
    '{24'h0FF0F0, AM_REL, LEN1, 2, 12'h011, 8'h00, 4'b0000, 16'h0},
    '{24'h13F0F0, AM_REL, LEN1, 2, 12'hFFE, 8'h00, 4'b0000, 16'h0},
    '{24'h23F0F0, AM_REL, LEN1, 2, 12'h002, 8'h00, 4'b0000, 16'h0},
    '{24'h43F0F0, AM_REL, LEN1, 2, 12'h005, 8'h00, 4'b0000, 16'h0},
    '{24'h63F0F0, AM_REL, LEN1, 2, 12'h002, 8'h00, 4'b0000, 16'h0},
    '{24'hBB20F0, AM_BITD, LEN2, 4, 12'h003, 8'h00, 4'b0001, 16'h2029},
    '{24'hB020F0, AM_BITD, LEN2, 4, 12'h003, 8'h00, 4'b0001, 16'h2020},
    '{24'hA82005, AM_BTB, LEN3, 5, 12'h007, 8'h00, 4'b0100, 16'h0},
    '{24'hA02005, AM_BTB, LEN3, 5, 12'h004, 8'h00, 4'b0100, 16'h0},
    '{24'hA720FE, AM_BTB, LEN3, 5, 12'h000, 8'h00, 4'b0000, 16'h0},
    '{24'hF5F0F0, AM_INH, LEN1, 4, 12'h002, 8'hFF, 4'b0000, 16'h0},
    '{24'hF0F0F0, AM_INH, LEN1, 2, 12'h002, 8'h00, 4'b0000, 16'h0},
    '{24'hE820F0, AM_DIR, LEN2, 4, 12'h003, 8'hDF, 4'b0100, 16'h0},
    '{24'hD0F0F0, AM_INH, LEN1, 2, 12'h002, 8'h00, 4'b0010, 16'h0},
    '{24'hEEF0F0, AM_INH, LEN1, 2, 12'h002, 8'h00, 4'b0010, 16'h0},
    '{24'hE421F0, AM_DIR, LEN2, 4, 12'h003, 8'h22, 4'b0000, 16'h0},
    '{24'hE5FFF0, AM_IMM, LEN2, 4, 12'h003, 8'hFF, 4'b0000, 16'h0},
    '{24'hE720F0, AM_IMM, LEN2, 4, 12'h003, 8'h00, 4'b1000, 16'h0},
    '{24'hE901F0, AM_IMM, LEN2, 4, 12'h003, 8'hFF, 4'b0100, 16'h0},
    '{24'hEA20F0, AM_DIR, LEN2, 4, 12'h003, 8'h00, 4'b0100, 16'h0},
    '{24'hEC20F0, AM_DIR, LEN2, 4, 12'h003, 8'h00, 4'b0001, 16'h2022},
    '{24'hED40F0, AM_DIR, LEN2, 4, 12'h003, 8'h00, 4'b0001, 16'h40FF},
    '{24'hF6F0F0, AM_INH, LEN1, 4, 12'h002, 8'h00, 4'b1000, 16'h0},
    '{24'hF7F0F0, AM_INH, LEN1, 4, 12'h002, 8'h00, 4'b1000, 16'h0},
    '{24'hF8F0F0, AM_INH, LEN1, 2, 12'h002, 8'h00, 4'b0010, 16'h0},
    '{24'hD4F0F0, AM_INH, LEN1, 2, 12'h002, 8'h00, 4'b0010, 16'h0}
  };

  cod_core u_dut (
    .MCLK       (MCLK),
    .RST        (RST),
    .PROG_ADDR  (PROG_ADDR),
    .PROG_RDATA (PROG_RDATA),
    .DATA_ADDR  (DATA_ADDR),
    .DATA_RD    (DATA_RD),
    .DATA_WE    (DATA_WE),
    .DATA_WDATA (DATA_WDATA),
    .DATA_RDATA (DATA_RDATA),
    .INT_REQ    (INT_REQ),
    .INT_VEC    (INT_VEC),
    .ACC        (ACC),
    .ZERO_FLAG  (ZERO_FLAG),
    .CARRY_FLAG (CARRY_FLAG),
    .ADDR_MODE  (ADDR_MODE),
    .INSTR_LEN  (INSTR_LEN),
    .INSTR_DONE (INSTR_DONE),
    .ILLEGAL    (ILLEGAL),
    .HALTED     (HALTED)
  );

  // ****************************************
  // Clock, memories and watchdog
  // ****************************************
  always #4 MCLK = ~MCLK;

  // Undriven read data toggles so a stale byte never passes
  // Writes use the edge's sampled strobe; reads answer the address
  // that this edge has just put out, so the byte is there next edge
  always @(posedge MCLK) begin
    if (DATA_WE === 1'b1)
      dmem[DATA_ADDR] = DATA_WDATA;
    if ((DATA_RD | DATA_WE) === 1'b1 &&
        (DATA_ADDR[7:2] === 6'h20 || DATA_ADDR === ADR_ACC))
      chk(12'h001, 12'h000);
    #1;
    PROG_RDATA = prog[PROG_ADDR];
    DATA_RDATA = (DATA_RD === 1'b1) ? dmem[DATA_ADDR] : ~DATA_RDATA;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic fill();
    foreach (prog[a]) prog[a] = 8'hF0;
    foreach (dmem[a]) dmem[a] = 8'(a + 1);
    dmem[8'h40] = 8'h00;
  endtask

  task automatic put(input logic [11:0] a, input logic [63:0] w);
    for (int k = 0; k < 8; k++)
      prog[a + 12'(k)] = w[63 - 8 * k -: 8];
  endtask

  // Reset lands in a running program, so it also covers mid-run reset
  task automatic do_reset();
    @(posedge MCLK);
    #1 RST = 1'b1;
    repeat (2) @(posedge MCLK);
    #1;
    chk(PROG_ADDR, 12'h000);
    chk(12'(ADDR_MODE), 12'h008);
    chk({1'b0, ACC, ZERO_FLAG, CARRY_FLAG, INSTR_DONE}, 12'h000);
    RST = 1'b0;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge MCLK);
      #2;
      n++;
    end while (INSTR_DONE !== 1'b1 && n < 50);
    if (INSTR_DONE !== 1'b1)
      chk(12'h001, 12'h000);
  endtask

  task automatic wait_addr(input logic [11:0] a);
    int n;
    n = 0;
    while (PROG_ADDR !== a && n < 20) begin
      @(posedge MCLK);
      #2;
      n++;
    end
    chk(PROG_ADDR, a);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    cod_row_t r;
    int       n;
    for (int i = 0; i < 38; i++) begin
      r = rows[i];
      fill();
      put(12'h001, {r.op, 40'hF0F0F0F0F0});
      do_reset();
      wait_done(n);
      wait_done(n);
      chk(12'(n), 12'(r.cy));
      chk(PROG_ADDR, r.npc);
      chk(12'(INSTR_LEN), 12'(r.ln));
      chk(12'(ILLEGAL), 12'(r.f[1]));
      if (r.f[1] == 1'b0)
        chk(12'(ADDR_MODE), 12'(r.md));
      chk({2'h0, ACC, ZERO_FLAG, CARRY_FLAG}, {2'h0, r.acc, r.f[3:2]});
      repeat (2) @(posedge MCLK);
      if (r.f[0] == 1'b1)
        chk(12'(dmem[r.m[15:8]]), 12'(r.m[7:0]));
      $display("row %0d done", i);
    end

    // Pointer choice by opcode bit 4
    fill();
    put(12'h000, 64'hE250C4E260C5C8D8);
    put(12'h008, 64'hC9F0F0F0F0F0F0F0);
    do_reset();
    repeat (5) wait_done(n);
    chk(12'(ACC), 12'h051);
    wait_done(n);
    chk(12'(ACC), 12'h061);
    wait_done(n);
    repeat (2) @(posedge MCLK);
    chk(12'(dmem[8'h50]), 12'h061);
    $display("indirect test done");

    // Six nested calls unwound in reverse order
    fill();
    for (int k = 0; k < 6; k++)
      put(12'(k * 256), {4'h9, 4'(k + 1), 16'h00F1, 40'hF0F0F0F0F0});
    prog[12'h002] = 8'hF0;
    prog[12'h600] = 8'hF1;
    do_reset();
    repeat (6) wait_done(n);
    for (int j = 5; j >= 0; j--) begin
      wait_done(n);
      chk(PROG_ADDR, 12'(j * 256 + 2));
    end
    $display("stack test done");

    // Wake from halt by interrupt, return through the stack
    fill();
    put(12'h000, 64'hF3F0F0F0F0F0F0F0);
    prog[12'h7A0] = 8'hF2;
    do_reset();
    wait_done(n);
    repeat (3) @(posedge MCLK);
    #2;
    chk(12'(HALTED), 12'h001);
    @(posedge MCLK);
    #1 INT_REQ = 1'b1;
    wait_addr(12'h7A0);
    @(posedge MCLK);
    #1 INT_REQ = 1'b0;
    wait_addr(12'h001);
    chk(12'(HALTED), 12'h000);
    $display("interrupt test done");
    results();
  end
endmodule // cod_core_bench
